/* rtl/rps_map.vh */
`ifndef RPS_MAP_VH
`define RPS_MAP_VH

// Clock rates
`define RPS_CLK_HZ          50000000
`define RPS_LF_HZ           32768

// Times in their own units
`define RPS_FILTER_US       2000
`define RPS_WINDOW_MS       2000
`define RPS_HOLD_MS         2400
`define RPS_RESTART_TICKS   17'h00002

// Divider and tick counts worked out from the rates and times above, sized to their registers
`define RPS_LF_DIV_DEF       11'h5F5
`define RPS_FILTER_TICKS_DEF 17'h00041
`define RPS_WINDOW_TICKS_DEF 17'h10000
`define RPS_HOLD_TICKS_DEF   17'h13333

// Widths
`define RPS_CNT_W           17
`define RPS_DIV_W           11
`define RPS_PIO_N           10
`define RPS_LED_N           3
`define RPS_MIC_N           3
`define RPS_SEL_W           3
`define RPS_IDX_W           4
`define RPS_BAUD_W          16

// Field positions
`define RPS_LED_PORT_HI     31
`define RPS_LED_PORT_LO     29
`define RPS_LAST_EVEN       4'h8

// Reset values
`define RPS_BAUD_RST        16'h0000
`define RPS_PIO_ALL         10'h3FF
`define RPS_PIO_NONE        10'h000
`define RPS_LED_ALL         3'h7
`define RPS_LED_NONE        3'h0
`define RPS_MIC_NONE        3'h0
// Pin pulls held during full chip reset
`define RPS_RST_PULL_EN     10'h3FF
`define RPS_RST_PULL_UP     10'h000
`define RPS_RST_PULL_STRONG 10'h000
`define RPS_RST_LED_PULL_EN 3'h7

`endif

/* rtl/rps_top.v */
`include "rps_map.vh"

module rps_top #(
   parameter [`RPS_DIV_W-1:0] LF_DIV       = `RPS_LF_DIV_DEF,
   parameter [`RPS_CNT_W-1:0] FILTER_TICKS = `RPS_FILTER_TICKS_DEF,
   parameter [`RPS_CNT_W-1:0] WINDOW_TICKS = `RPS_WINDOW_TICKS_DEF,
   parameter [`RPS_CNT_W-1:0] HOLD_TICKS   = `RPS_HOLD_TICKS_DEF
) (
   input  wire                        clock_i,
   input  wire                        rst_n_i,
   input  wire                        ext_reset_n_i,
   input  wire                        esd_event_i,
   input  wire                        app_reset_req_i,
   input  wire                        regulator_enable_in_i,
   input  wire                        charger_supply_in_i,
   input  wire                        baud_we_i,
   input  wire [`RPS_BAUD_W-1:0]      baud_cfg_i,
   input  wire                        ram_loaded_i,
   input  wire [31:0]                 output_port_bits_i,
   input  wire [`RPS_PIO_N-1:0]       pio_in_i,
   input  wire [`RPS_PIO_N-1:0]       pio_out_i,
   input  wire [`RPS_PIO_N-1:0]       pio_drive_i,
   input  wire [`RPS_PIO_N-1:0]       pio_pull_en_i,
   input  wire [`RPS_PIO_N-1:0]       pio_pull_up_i,
   input  wire [`RPS_PIO_N-1:0]       pio_pull_strong_i,
   input  wire [`RPS_MIC_N-1:0]       mic_en_i,
   input  wire [`RPS_MIC_N-1:0]       mic_clk_i,
   input  wire [`RPS_MIC_N*`RPS_SEL_W-1:0] mic_clk_sel_i,
   input  wire [`RPS_MIC_N*`RPS_SEL_W-1:0] mic_dat_sel_i,
   output reg                         power_on_o,
   output reg                         core_reset_n_o,
   output reg                         protect_active_o,
   output reg                         last_reset_cold_o,
   output reg  [`RPS_BAUD_W-1:0]      baud_setting_o,
   output reg                         ram_valid_o,
   output reg  [`RPS_PIO_N-1:0]       pio_o,
   output reg  [`RPS_PIO_N-1:0]       pio_oe_n_o,
   output reg  [`RPS_PIO_N-1:0]       pio_pull_en_o,
   output reg  [`RPS_PIO_N-1:0]       pio_pull_up_o,
   output reg  [`RPS_PIO_N-1:0]       pio_pull_strong_o,
   output reg  [`RPS_LED_N-1:0]       led_o,
   output reg  [`RPS_LED_N-1:0]       led_oe_n_o,
   output reg  [`RPS_LED_N-1:0]       led_pull_down_o,
   output reg  [`RPS_MIC_N-1:0]       mic_data_o
);

   localparam [1:0] ST_OFF     = 2'h0;
   localparam [1:0] ST_RESTART = 2'h1;
   localparam [1:0] ST_RUN     = 2'h2;
   localparam [1:0] ST_PINHOLD = 2'h3;

   // Even pin for a microphone clock, clipped to the last even pin
   function [`RPS_IDX_W-1:0] rps_even_pin;
      input [`RPS_SEL_W-1:0] sel;
      reg   [`RPS_IDX_W-1:0] idx;
      begin
         idx = {sel, 1'b0};
         if (idx > `RPS_LAST_EVEN)
            idx = `RPS_LAST_EVEN;
         rps_even_pin = idx;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Low-frequency tick and supply edge detection

   reg  [`RPS_DIV_W-1:0] div_cnt;
   reg                   lf_tick;
   reg                   reg_en_prev;
   reg                   chg_prev;
   wire                  power_edge;

   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_cnt <= {`RPS_DIV_W{1'b0}};
         lf_tick <= 1'b0;
      end else if (div_cnt >= LF_DIV - 1'b1) begin
         div_cnt <= {`RPS_DIV_W{1'b0}};
         lf_tick <= 1'b1;
      end else begin
         div_cnt <= div_cnt + 1'b1;
         lf_tick <= 1'b0;
      end
   end

   // Held high at reset so a supply already present is not an edge
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_en_prev <= 1'b1;
         chg_prev    <= 1'b1;
      end else begin
         reg_en_prev <= regulator_enable_in_i;
         chg_prev    <= charger_supply_in_i;
      end
   end

   assign power_edge = (regulator_enable_in_i & ~reg_en_prev) | (charger_supply_in_i & ~chg_prev);

   ////////////////////////////////////////////////////////////////////////
   // Reset pin filter and hold counter

   reg  [`RPS_CNT_W-1:0] low_cnt;
   wire                  pin_filtered;
   wire                  pin_too_long;

   // One counter serves both the glitch filter and the power-off limit
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i)
         low_cnt <= {`RPS_CNT_W{1'b0}};
      else if (ext_reset_n_i)
         low_cnt <= {`RPS_CNT_W{1'b0}};
      else if (lf_tick && low_cnt != {`RPS_CNT_W{1'b1}})
         low_cnt <= low_cnt + 1'b1;
   end

   assign pin_filtered = ~ext_reset_n_i && (low_cnt >= FILTER_TICKS);
   assign pin_too_long = ~ext_reset_n_i && (low_cnt > HOLD_TICKS);

   ////////////////////////////////////////////////////////////////////////
   // Sequencer

   reg  [1:0]            state;
   reg  [1:0]            next_state;
   reg  [`RPS_CNT_W-1:0] rst_cnt;
   reg  [`RPS_CNT_W-1:0] win_cnt;
   reg                   next_protect;
   reg                   cold_pending;
   wire                  unexpected;
   wire                  in_reset;

   assign unexpected = esd_event_i | app_reset_req_i;

   always @* begin
      next_state = state;
      case (state)
         ST_OFF: begin
            if (power_edge)
               next_state = ST_RESTART;
         end
         ST_RESTART: begin
            if (pin_filtered)
               next_state = ST_PINHOLD;
            else if (rst_cnt >= `RPS_RESTART_TICKS)
               next_state = ST_RUN;
         end
         ST_RUN: begin
            if (pin_filtered)
               next_state = ST_PINHOLD;
            else if (unexpected)
               next_state = ST_RESTART;
         end
         ST_PINHOLD: begin
            if (pin_too_long)
               next_state = ST_OFF;
            else if (ext_reset_n_i)
               next_state = ST_RESTART;
         end
         default: next_state = ST_OFF;
      endcase
   end

   assign in_reset = (state != ST_RUN);

   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state        <= ST_OFF;
         rst_cnt      <= {`RPS_CNT_W{1'b0}};
         cold_pending <= 1'b1;
      end else begin
         state <= next_state;
         if (next_state != ST_RESTART || state != ST_RESTART)
            rst_cnt <= {`RPS_CNT_W{1'b0}};
         else if (lf_tick)
            rst_cnt <= rst_cnt + 1'b1;
         if (state == ST_OFF)
            cold_pending <= 1'b1;
         else if (state == ST_RUN)
            cold_pending <= 1'b0;
      end
   end

   // Window restarts on every unexpected reset seen while running
   always @* begin
      next_protect = protect_active_o;
      if (state == ST_OFF || next_state == ST_OFF)
         next_protect = 1'b0;
      else if (state == ST_RUN && next_state != ST_RUN)
         next_protect = 1'b1;
      else if (protect_active_o && win_cnt == {`RPS_CNT_W{1'b0}})
         next_protect = 1'b0;
   end

   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         win_cnt          <= {`RPS_CNT_W{1'b0}};
         protect_active_o <= 1'b0;
      end else begin
         protect_active_o <= next_protect;
         if (state == ST_RUN && next_state != ST_RUN)
            win_cnt <= WINDOW_TICKS;
         else if (lf_tick && win_cnt != {`RPS_CNT_W{1'b0}})
            win_cnt <= win_cnt - 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Retained state kept across warm resets, cleared while powered off (cold)

   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         power_on_o        <= 1'b0;
         core_reset_n_o    <= 1'b0;
         last_reset_cold_o <= 1'b1;
         baud_setting_o    <= `RPS_BAUD_RST;
         ram_valid_o       <= 1'b0;
      end else begin
         power_on_o     <= (next_state != ST_OFF);
         core_reset_n_o <= (next_state == ST_RUN);
         if (state == ST_OFF) begin
            baud_setting_o <= `RPS_BAUD_RST;
            ram_valid_o    <= 1'b0;
         end else if (!in_reset) begin
            if (baud_we_i)
               baud_setting_o <= baud_cfg_i;
            if (ram_loaded_i)
               ram_valid_o <= 1'b1;
         end
         if (state != ST_RUN && next_state == ST_RUN)
            last_reset_cold_o <= cold_pending;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin control

   reg  [`RPS_PIO_N-1:0] next_pio;
   reg  [`RPS_PIO_N-1:0] next_oe_n;
   reg  [`RPS_MIC_N-1:0] next_mic;
   reg  [`RPS_IDX_W-1:0] clk_pin;
   reg  [`RPS_IDX_W-1:0] dat_pin;
   integer               m;

   always @* begin
      next_pio  = pio_out_i;
      next_oe_n = ~pio_drive_i;
      next_mic  = `RPS_MIC_NONE;
      clk_pin   = {`RPS_IDX_W{1'b0}};
      dat_pin   = {`RPS_IDX_W{1'b0}};
      for (m = 0; m < `RPS_MIC_N; m = m + 1) begin
         clk_pin = rps_even_pin(mic_clk_sel_i[m*`RPS_SEL_W +: `RPS_SEL_W]);
         dat_pin = rps_even_pin(mic_dat_sel_i[m*`RPS_SEL_W +: `RPS_SEL_W]) + 1'b1;
         if (mic_en_i[m]) begin
            next_pio[clk_pin]  = mic_clk_i[m];
            next_oe_n[clk_pin] = 1'b0;
            next_oe_n[dat_pin] = 1'b1;
            next_mic[m]        = pio_in_i[dat_pin];
         end
      end
      if (in_reset)
         next_oe_n = `RPS_PIO_ALL;
   end

   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pio_o             <= `RPS_PIO_NONE;
         pio_oe_n_o        <= `RPS_PIO_ALL;
         pio_pull_en_o     <= `RPS_RST_PULL_EN;
         pio_pull_up_o     <= `RPS_RST_PULL_UP;
         pio_pull_strong_o <= `RPS_RST_PULL_STRONG;
         led_o             <= `RPS_LED_NONE;
         led_oe_n_o        <= `RPS_LED_ALL;
         led_pull_down_o   <= `RPS_RST_LED_PULL_EN;
         mic_data_o        <= `RPS_MIC_NONE;
      end else begin
         pio_o      <= next_pio;
         pio_oe_n_o <= next_oe_n;
         mic_data_o <= in_reset ? `RPS_MIC_NONE : next_mic;
         led_o      <= output_port_bits_i[`RPS_LED_PORT_HI:`RPS_LED_PORT_LO];
         if (in_reset) begin
            pio_pull_en_o     <= `RPS_RST_PULL_EN;
            pio_pull_up_o     <= `RPS_RST_PULL_UP;
            pio_pull_strong_o <= `RPS_RST_PULL_STRONG;
            led_oe_n_o        <= `RPS_LED_ALL;
            led_pull_down_o   <= `RPS_RST_LED_PULL_EN;
         end else begin
            pio_pull_en_o     <= pio_pull_en_i;
            pio_pull_up_o     <= pio_pull_up_i;
            pio_pull_strong_o <= pio_pull_strong_i;
            led_oe_n_o        <= `RPS_LED_NONE;
            led_pull_down_o   <= `RPS_LED_NONE;
         end
      end
   end

endmodule // rps_top

/* test/rps_chk_assertions.sv */
`include "rps_map.vh"

module rps_chk #(
   parameter [`RPS_DIV_W-1:0] LF_DIV       = 4,
   parameter [`RPS_CNT_W-1:0] FILTER_TICKS = 2,
   parameter [`RPS_CNT_W-1:0] WINDOW_TICKS = 20,
   parameter [`RPS_CNT_W-1:0] HOLD_TICKS   = 30
) (
   input wire        clock_i,
   input wire        rst_n_i,
   input wire        ext_reset_n_i,
   input wire [31:0] output_port_bits_i,
   input wire [2:0]  mic_en_i,
   input wire [2:0]  mic_clk_i,
   input wire [8:0]  mic_clk_sel_i,
   input wire        power_on_o,
   input wire        core_reset_n_o,
   input wire        protect_active_o,
   input wire [15:0] baud_setting_o,
   input wire        ram_valid_o,
   input wire [9:0]  pio_o,
   input wire [9:0]  pio_oe_n_o,
   input wire [9:0]  pio_pull_en_o,
   input wire [2:0]  led_o,
   input wire [2:0]  led_oe_n_o,
   input wire [2:0]  led_pull_down_o,
   input wire [2:0]  mic_data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   ////////////////////////////////////////////////////////////
   chk_led_port_map: assert property (core_reset_n_o |=> led_o == $past(output_port_bits_i[31:29]))
      else $error("status lights do not follow port bits");
   chk_led_reset_pull: assert property (!core_reset_n_o |=> led_oe_n_o == 3'h7 && led_pull_down_o == 3'h7)
      else $error("status lights not tristate with pull-down in reset");
   chk_pio_reset_state: assert property (!core_reset_n_o |=> pio_oe_n_o == 10'h3FF && pio_pull_en_o == 10'h3FF)
      else $error("pins not inputs with pulls in reset");
   chk_warm_keeps_baud: assert property (!core_reset_n_o && power_on_o ##1 power_on_o |-> $stable(baud_setting_o))
      else $error("baud setting changed across warm reset");
   chk_off_clears_state: assert property (!power_on_o [*2] |-> baud_setting_o == 16'h0000 && !ram_valid_o)
      else $error("retained state survives power off");
   chk_fall_arms_window: assert property ($fell(core_reset_n_o) |-> ##[0:1] protect_active_o)
      else $error("core reset without protection window");
   chk_pin_filter_delay: assert property ($fell(core_reset_n_o) && !ext_reset_n_i |-> $past(ext_reset_n_i, 4) == 1'b0)
      else $error("reset pin acted on before filtering");
   chk_window_bounded: assert property ($rose(protect_active_o) |-> protect_active_o [*8] ##[1:300] !protect_active_o)
      else $error("protection window length out of bounds");
   chk_mic_clock_pin: assert property (core_reset_n_o && mic_en_i == 3'h1 && mic_clk_sel_i[2:0] == 3'h0
      |=> !pio_oe_n_o[0] && pio_o[0] == $past(mic_clk_i[0]))
      else $error("mic clock not on selected even pin");
endmodule // rps_chk

/* test/rps_host.sv */
module rps_host (
   input  wire  clock_i,
   output logic ext_reset_n_o         = 1'b1,
   output logic regulator_enable_in_o = 1'b0,
   output logic charger_supply_in_o   = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   // Supplies start low so a level already present is never mistaken for an edge
   task automatic supply_edge(input bit chg);
      @(posedge clock_i) #2;
      if (chg) charger_supply_in_o = 1'b0;
      else regulator_enable_in_o = 1'b0;
      @(posedge clock_i) #2;
      if (chg) charger_supply_in_o = 1'b1;
      else regulator_enable_in_o = 1'b1;
   endtask
   task automatic pin_low(input int n);
      @(posedge clock_i) #2 ext_reset_n_o = 1'b0;
      repeat (n) @(posedge clock_i);
      #2 ext_reset_n_o = 1'b1;
   endtask
endmodule // rps_host

/* test/rps_top_bench.sv */
`include "rps_map.vh"

module rps_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DIV = 4, FILT = 2, WIN = 20, HOLD = 30;
   logic        clock_i = 1'b0, rst_n_i = 1'b0, esd = 1'b0, app = 1'b0, baud_we = 1'b0, ram_ld = 1'b0;
   logic [15:0] baud_cfg = 16'h0000;
   logic [31:0] port_bits = 32'h0000_0000;
   logic [9:0]  pio_in = 10'h000, pull_en = 10'h000, pio_out = 10'h000, pio_drive = 10'h000;
   logic [8:0]  dat_sel = 9'h000;
   logic [2:0]  mic_en = 3'h0, mic_clk = 3'h0;
   wire         ext_n, reg_en, chg;
   int          error_cnt = 0, n_checks = 0;
   rps_host host (.clock_i(clock_i), .ext_reset_n_o(ext_n), .regulator_enable_in_o(reg_en), .charger_supply_in_o(chg));
   // Outputs are observed through the instance so no copy of them can drift
   rps_top #(.LF_DIV(DIV), .FILTER_TICKS(FILT), .WINDOW_TICKS(WIN), .HOLD_TICKS(HOLD)) dut (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .ext_reset_n_i(ext_n), .esd_event_i(esd), .app_reset_req_i(app),
      .regulator_enable_in_i(reg_en), .charger_supply_in_i(chg), .baud_we_i(baud_we), .baud_cfg_i(baud_cfg),
      .ram_loaded_i(ram_ld), .output_port_bits_i(port_bits), .pio_in_i(pio_in), .pio_out_i(pio_out),
      .pio_drive_i(pio_drive), .pio_pull_en_i(pull_en), .pio_pull_up_i(10'h000), .pio_pull_strong_i(10'h000),
      .mic_en_i(mic_en), .mic_clk_i(mic_clk), .mic_clk_sel_i(9'h000), .mic_dat_sel_i(dat_sel),
      .power_on_o(), .core_reset_n_o(), .protect_active_o(), .last_reset_cold_o(), .baud_setting_o(),
      .ram_valid_o(), .pio_o(), .pio_oe_n_o(), .pio_pull_en_o(), .pio_pull_up_o(), .pio_pull_strong_o(),
      .led_o(), .led_oe_n_o(), .led_pull_down_o(), .mic_data_o());
   ////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clock_i);
      #2;
   endtask
   task automatic wait_core(input logic v, input int max);
      int i;
      for (i = 0; i < max && dut.core_reset_n_o !== v; i++) step(1);
      check(dut.core_reset_n_o, v);
   endtask
   task automatic report_and_stop;
      if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_reset;
      check(dut.pio_oe_n_o, 10'h3FF);
      check({dut.pio_pull_en_o, dut.pio_pull_up_o, dut.pio_pull_strong_o}, {10'h3FF, 20'h00000});
      check({dut.led_oe_n_o, dut.led_pull_down_o}, 6'h3F);
   endtask
   task automatic t_power(input bit use_chg);
      host.supply_edge(use_chg);
      wait_core(1'b1, 40);
      check({dut.power_on_o, dut.last_reset_cold_o}, 2'h3);
      check({dut.baud_setting_o, dut.ram_valid_o}, 17'h00000);
   endtask
   task automatic t_run;
      baud_cfg = 16'hA5C3;
      baud_we = 1'b1;
      ram_ld = 1'b1;
      port_bits = 32'hA000_0000;
      pull_en = 10'h155;
      mic_en = 3'h1;
      mic_clk = 3'h1;
      pio_in = 10'h200;
      pio_out = 10'h004;
      pio_drive = 10'h204;
      dat_sel = 9'h007;
      step(1);
      baud_we = 1'b0;
      ram_ld = 1'b0;
      step(2);
      check(dut.led_o, 3'h5);
      check({dut.pio_oe_n_o[0], dut.pio_o[0], dut.mic_data_o}, 5'h09);
      check({dut.pio_oe_n_o[9], dut.pio_oe_n_o[2], dut.pio_o[2]}, 3'h5);
      check(dut.pio_pull_en_o, 10'h155);
      check({dut.baud_setting_o, dut.ram_valid_o}, {16'hA5C3, 1'b1});
   endtask
   task automatic t_pin;
      realtime t0;
      int n;
      fork
         host.pin_low(20);
      join_none
      step(3);
      check(dut.core_reset_n_o, 1'b1);
      wait_core(1'b0, 30);
      t0 = $realtime;
      step(1);
      check({dut.protect_active_o, dut.pio_oe_n_o, dut.led_oe_n_o, dut.mic_data_o}, {1'b1, 10'h3FF, 6'h38});
      wait_core(1'b1, 60);
      check({dut.last_reset_cold_o, dut.baud_setting_o, dut.ram_valid_o}, {1'b0, 16'hA5C3, 1'b1});
      for (n = 0; n < 400 && dut.protect_active_o !== 1'b0; n++) step(1);
      n = int'(($realtime - t0) / 20.0);
      check(n >= WIN * DIV * 4 / 5 && n <= WIN * DIV * 6 / 5, 1'b1);
   endtask
   task automatic t_events;
      for (int k = 0; k < 2; k++) begin
         if (k == 0) esd = 1'b1;
         else app = 1'b1;
         step(1);
         esd = 1'b0;
         app = 1'b0;
         wait_core(1'b0, 8);
         if (k == 0) check(dut.protect_active_o, 1'b1);
         wait_core(1'b1, 40);
         check({dut.last_reset_cold_o, dut.ram_valid_o}, 2'h1);
      end
   endtask
   task automatic t_hold;
      host.pin_low(HOLD * DIV + 40);
      step(12);
      check({dut.power_on_o, dut.protect_active_o, dut.core_reset_n_o}, 3'h0);
      check({dut.baud_setting_o, dut.ram_valid_o}, 17'h00000);
      t_power(1'b1);
   endtask
   ////////////////////////////////////////////////////////////
   initial forever #10 clock_i = ~clock_i;
   initial begin
      step(10);
      t_reset;
      rst_n_i = 1'b1;
      step(5);
      check(dut.power_on_o, 1'b0);
      t_power(1'b0);
      t_run;
      t_pin;
      t_events;
      t_hold;
      report_and_stop;
   end
   // Whole sequence needs a few hundred cycles; 10000 cycles, far beyond that, is a hang
   initial begin
      #200000;
      error_cnt++;
      report_and_stop;
   end
endmodule // rps_top_bench

bind rps_top rps_chk #(.LF_DIV(LF_DIV), .FILTER_TICKS(FILTER_TICKS), .WINDOW_TICKS(WINDOW_TICKS),
   .HOLD_TICKS(HOLD_TICKS)) u_chk (
   .clock_i(clock_i), .rst_n_i(rst_n_i), .ext_reset_n_i(ext_reset_n_i), .output_port_bits_i(output_port_bits_i),
   .mic_en_i(mic_en_i), .mic_clk_i(mic_clk_i), .mic_clk_sel_i(mic_clk_sel_i), .power_on_o(power_on_o),
   .core_reset_n_o(core_reset_n_o), .protect_active_o(protect_active_o), .baud_setting_o(baud_setting_o),
   .ram_valid_o(ram_valid_o), .pio_o(pio_o), .pio_oe_n_o(pio_oe_n_o), .pio_pull_en_o(pio_pull_en_o),
   .led_o(led_o), .led_oe_n_o(led_oe_n_o), .led_pull_down_o(led_pull_down_o), .mic_data_o(mic_data_o));
